// *** design/bus_wait_ctrl.sv ***
// External area bus width, access state and wait-state control with an AXI4-Lite register slave.
`timescale 1ns/10ps
module bus_wait_ctrl
   import bus_wait_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // AXI4-Lite slave.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // External access sequencing.
   input wire logic accStart,
   input wire logic [2:0] accArea,
   input wire logic extWait,
   output logic accBusy,
   output logic accDone,
   output logic accByteWide,
   output logic accWaitState
);
   logic [7:0] widthSel_q, stateSel_q, waitEn_q, wByte_q;
   wait_cfg_t waitCfg_q;
   logic awHeld_q, wHeld_q, wLane_q, rdHit_d, wrHit_d, pinWait_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [31:0] rdData_d;
   acc_state_t state_q;
   logic [2:0] area_q;
   logic [1:0] waitCnt_q;

   // Write address and data are taken in either order and held.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wByte_q <= 8'h00;
         wLane_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
      end
      else if (awHeld_q && wHeld_q)
      begin
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_q <= 1'b1;
            wByte_q <= s_axi_wdata[7:0];
            wLane_q <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
            {s_axi_awready, s_axi_wready} <= 2'h3;
      end
   end
   always_comb
   begin
      wrHit_d = (awAddr_q == regAddr(IDX_WIDTH_SEL)) || (awAddr_q == regAddr(IDX_STATE_SEL))
         || (awAddr_q == regAddr(IDX_WAIT_MODE)) || (awAddr_q == regAddr(IDX_WAIT_EN));
   end
   // Write response after both halves are held.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (awHeld_q && wHeld_q)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrHit_d ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Configuration registers, byte lane 0 only.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         widthSel_q <= RST_WIDTH_SEL;
         stateSel_q <= RST_STATE_SEL;
         waitCfg_q <= RST_WAIT_MODE[3:0];
         waitEn_q <= RST_WAIT_EN;
      end
      else if (awHeld_q && wHeld_q && wLane_q)
      begin
         if (awAddr_q == regAddr(IDX_WIDTH_SEL))
            widthSel_q <= wByte_q;
         if (awAddr_q == regAddr(IDX_STATE_SEL))
            stateSel_q <= wByte_q;
         if (awAddr_q == regAddr(IDX_WAIT_MODE))
            waitCfg_q <= wByte_q[3:0];
         if (awAddr_q == regAddr(IDX_WAIT_EN))
            waitEn_q <= wByte_q;
      end
   end

   always_comb
   begin
      rdHit_d = 1'b1;
      rdData_d = 32'h0000_0000;
      if (s_axi_araddr == regAddr(IDX_WIDTH_SEL))
         rdData_d[7:0] = widthSel_q;
      else if (s_axi_araddr == regAddr(IDX_STATE_SEL))
         rdData_d[7:0] = stateSel_q;
      else if (s_axi_araddr == regAddr(IDX_WAIT_MODE))
         rdData_d[7:0] = {WAIT_UNUSED_ONES, waitCfg_q};
      else if (s_axi_araddr == regAddr(IDX_WAIT_EN))
         rdData_d[7:0] = waitEn_q;
      else if (s_axi_araddr == regAddr(IDX_STATUS))
         rdData_d[7:0] = {accWaitState, accBusy, 3'h0, area_q};
      else
         rdHit_d = 1'b0;
   end
   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
         s_axi_arready <= 1'b1;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdData_d;
         s_axi_rresp <= rdHit_d ? RESP_OKAY : RESP_SLVERR;
         s_axi_arready <= 1'b0;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // Access sequencer: T1, T2, optional waits, T3 for three-state areas.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         state_q <= ST_IDLE;
         area_q <= 3'h0;
         waitCnt_q <= 2'h0;
         pinWait_q <= 1'b0;
         accDone <= 1'b0;
         accByteWide <= 1'b0;
      end
      else
      begin
         accDone <= 1'b0;
         case (state_q)
            ST_IDLE:
               if (accStart)
               begin
                  area_q <= accArea;
                  accByteWide <= widthSel_q[accArea];
                  state_q <= ST_T1;
               end
            ST_T1:
               state_q <= ST_T2;
            ST_T2:
               if (!stateSel_q[area_q])
               begin
                  accDone <= 1'b1;
                  state_q <= ST_IDLE;
               end
               else if (!waitEn_q[area_q])
               begin
                  pinWait_q <= 1'b1;
                  state_q <= extWait ? ST_TW : ST_T3;
               end
               else
               begin
                  case (waitCfg_q.mode)
                     WM_PROGRAMMED:
                     begin
                        pinWait_q <= 1'b0;
                        waitCnt_q <= waitCfg_q.count - 2'h1;
                        state_q <= (waitCfg_q.count == 2'h0) ? ST_T3 : ST_TW;
                     end
                     WM_NONE:
                        state_q <= ST_T3;
                     WM_PIN:
                     begin
                        pinWait_q <= 1'b1;
                        state_q <= extWait ? ST_TW : ST_T3;
                     end
                     WM_PIN_AUTO:
                     begin
                        pinWait_q <= 1'b0;
                        waitCnt_q <= waitCfg_q.count - 2'h1;
                        state_q <= (extWait && waitCfg_q.count != 2'h0) ? ST_TW : ST_T3;
                     end
                     default:
                        state_q <= ST_T3;
                  endcase
               end
            ST_TW:
               if (pinWait_q ? !extWait : (waitCnt_q == 2'h0))
                  state_q <= ST_T3;
               else if (!pinWait_q)
                  waitCnt_q <= waitCnt_q - 2'h1;
            ST_T3:
            begin
               accDone <= 1'b1;
               state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         accBusy <= 1'b0;
         accWaitState <= 1'b0;
      end
      else
      begin
         accBusy <= (state_q == ST_IDLE) ? accStart : !(state_q == ST_T3 || (state_q == ST_T2 && !stateSel_q[area_q]));
         accWaitState <= (state_q == ST_T2 && stateSel_q[area_q] && waitCfg_q.mode != WM_NONE
            && (waitEn_q[area_q] ? (waitCfg_q.mode == WM_PIN ? extWait
            : (waitCfg_q.mode == WM_PROGRAMMED ? waitCfg_q.count != 2'h0 : extWait && waitCfg_q.count != 2'h0))
            : extWait)) || (state_q == ST_TW && !(pinWait_q ? !extWait : waitCnt_q == 2'h0))
            || (state_q == ST_T2 && stateSel_q[area_q] && !waitEn_q[area_q] && extWait);
      end
   end

   a_width_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_q == ST_IDLE && accStart) |=> (accByteWide == widthSel_q[area_q]))
      else $error("Bus width not taken from area width bit.");
   a_two_state: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_q == ST_IDLE && accStart && !stateSel_q[accArea]) |-> ##3 accDone)
      else $error("Two-state access did not end after two states.");
   a_no_wait_mode: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_q == ST_T2 && stateSel_q[area_q] && waitEn_q[area_q] && waitCfg_q.mode == WM_NONE) |=> state_q == ST_T3)
      else $error("Waits inserted in no-wait mode.");
   a_prog_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_q == ST_T2 && stateSel_q[area_q] && waitEn_q[area_q] && waitCfg_q.mode == WM_PROGRAMMED
      && waitCfg_q.count == 2'h3) |=> (state_q == ST_TW) [*3] ##1 state_q == ST_T3)
      else $error("Programmed wait count not honoured.");
   a_mode_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_q == ST_T2 && stateSel_q[area_q] && waitEn_q[area_q] && waitCfg_q.mode == WM_PIN && !extWait)
      |=> state_q == ST_T3)
      else $error("Pin wait mode entered wait without the pin.");
   a_area_enable: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_q == ST_T2 && stateSel_q[area_q] && !waitEn_q[area_q] && !extWait) |=> state_q == ST_T3)
      else $error("Disabled area got controller waits.");
   a_pin_mode0: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_q == ST_T2 && stateSel_q[area_q] && !waitEn_q[area_q] && extWait) |=> state_q == ST_TW)
      else $error("Pin wait mode 0 ignored the wait pin.");
   a_two_no_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
      (state_q == ST_T2 && !stateSel_q[area_q]) |=> (state_q == ST_IDLE && accDone))
      else $error("Two-state access got wait states.");
endmodule

// *** shared/bus_wait_pkg.sv ***
// Constants and types for the external area bus configuration and wait control block.
package bus_wait_pkg;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_WIDTH_SEL = 8'hEC;
   localparam logic [7:0] IDX_STATE_SEL = 8'hED;
   localparam logic [7:0] IDX_WAIT_MODE = 8'hEE;
   localparam logic [7:0] IDX_WAIT_EN = 8'hEF;
   localparam logic [7:0] IDX_STATUS = 8'hF0;
   localparam int ADDR_W = 12;
   // Reset values.
   localparam logic [7:0] RST_WIDTH_SEL = 8'hFF;
   localparam logic [7:0] RST_STATE_SEL = 8'hFF;
   localparam logic [7:0] RST_WAIT_MODE = 8'hF3;
   localparam logic [7:0] RST_WAIT_EN = 8'hFF;
   // Field positions of the wait mode and count register.
   localparam int WMODE_LSB = 2;
   localparam int WCOUNT_LSB = 0;
   localparam logic [3:0] WAIT_UNUSED_ONES = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      WM_PROGRAMMED = 2'b00,
      WM_NONE = 2'b01,
      WM_PIN = 2'b10,
      WM_PIN_AUTO = 2'b11
   } wait_mode_t;

   typedef struct packed
   {
      wait_mode_t mode;
      logic [1:0] count;
   } wait_cfg_t;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_T1 = 3'b001,
      ST_T2 = 3'b010,
      ST_TW = 3'b011,
      ST_T3 = 3'b100
   } acc_state_t;

   function automatic logic [ADDR_W-1:0] regAddr(input logic [7:0] idx);
      regAddr = {2'h0, idx, 2'h0};
   endfunction
endpackage

// *** test/ext_dev_model.sv ***
// External device model that stalls an access by holding the wait pin.
`timescale 1ns/10ps
module ext_dev_model
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Access observed and stall length commanded by the bench.
   input wire logic accStart,
   input wire logic accBusy,
   input wire logic [2:0] holdCycles,
   // Wait pin, pulled inactive while the device does not stall.
   output logic extWait
);
   logic [3:0] holdLeft_q;

   // The stall starts in the first state and lasts holdCycles cycles past the first state.
   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         holdLeft_q <= 4'h0;
      else if (accStart && !accBusy)
         holdLeft_q <= {1'b0, holdCycles} + 4'h1;
      else if (holdLeft_q != 4'h0)
         holdLeft_q <= holdLeft_q - 4'h1;
   end

   assign extWait = (holdLeft_q != 4'h0);
endmodule

// *** test/tb_top.sv ***
// Testbench for the external area bus configuration and wait control block.
`timescale 1ns/10ps
module tb_top
   import bus_wait_pkg::*;
;
   logic clk_sys, sys_rst, awValid, awReady, wValid, wReady, bValid, arValid, arReady, rValid;
   logic accStart, accBusy, accDone, accByteWide, accWaitState, extWait;
   logic [ADDR_W-1:0] awAddr, arAddr;
   logic [31:0] wData, rData;
   logic [1:0] bResp, rResp;
   logic [2:0] accArea, holdCycles;
   logic [7:0] widthSel, stateSel, waitEn;
   int num_errors = 0;
   int num_checks = 0;

   bus_wait_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
      .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'b1),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
      .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'b1), .accStart(accStart),
      .accArea(accArea), .extWait(extWait), .accBusy(accBusy), .accDone(accDone),
      .accByteWide(accByteWide), .accWaitState(accWaitState));

   ext_dev_model model (.clk_sys(clk_sys), .sys_rst(sys_rst), .accStart(accStart), .accBusy(accBusy),
      .holdCycles(holdCycles), .extWait(extWait));

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic test_done();
      if (num_errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic timeout(input int n);
      if (n >= 50)
      begin
         num_errors++;
         $display("mismatch at %0t: no answer", $time);
         test_done();
      end
   endtask

   task automatic axWrite(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awAddr <= {2'h0, idx, 2'h0};
      wData <= {24'h0, d};
      awValid <= 1'b1;
      wValid <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (awReady === 1'b1)
            awValid <= 1'b0;
         if (wReady === 1'b1)
            wValid <= 1'b0;
         n++;
      end while (bValid !== 1'b1 && n < 50);
      timeout(n);
      chk({30'h0, bResp}, {30'h0, er}, "write response");
   endtask

   task automatic axRead(input logic [7:0] idx, input logic [7:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      arAddr <= {2'h0, idx, 2'h0};
      arValid <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (arReady === 1'b1)
            arValid <= 1'b0;
         n++;
      end while (rValid !== 1'b1 && n < 50);
      timeout(n);
      chk({30'h0, rResp}, {30'h0, er}, "read response");
      chk(rData, {24'h0, ed}, "read data");
   endtask

   // Cycles from the taking edge to the end of the access, as the configuration demands.
   function automatic int expCycles(input logic [2:0] a, input logic [1:0] m, input logic [1:0] c, input int h);
      if (!stateSel[a])
         return 3;
      if (!waitEn[a])
         return 4 + h;
      case (m)
         2'b00: return 4 + c;
         2'b01: return 4;
         2'b10: return 4 + h;
         default: return (h > 0) ? 4 + c : 4;
      endcase
   endfunction

   task automatic access(input logic [2:0] a, input logic [1:0] m, input logic [1:0] c, input int h);
      int n;
      int w;
      int b;
      int e;
      axWrite(IDX_WAIT_MODE, {4'h0, m, c}, RESP_OKAY);
      accStart <= 1'b1;
      accArea <= a;
      holdCycles <= h[2:0];
      @(posedge clk_sys);
      accStart <= 1'b0;
      n = 0;
      w = 0;
      b = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
         if (accWaitState === 1'b1)
            w++;
         if (accBusy === 1'b1)
            b++;
      end while (accDone !== 1'b1 && n < 50);
      timeout(n);
      e = expCycles(a, m, c, h);
      chk(n, e, "access length");
      chk(b, e - 1, "busy cycles");
      chk(w, (e > 3) ? e - 4 : 0, "wait states");
      chk({31'h0, accByteWide}, {31'h0, widthSel[a]}, "bus width");
   endtask

   initial
   begin
      {awValid, wValid, arValid, accStart} = 4'h0;
      {awAddr, arAddr, wData, accArea, holdCycles} = '0;
      widthSel = 8'h5A;
      stateSel = 8'hEE;
      waitEn = 8'hF7;
      sys_rst = 1'b1;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      axRead(IDX_WIDTH_SEL, RST_WIDTH_SEL, RESP_OKAY);
      axRead(IDX_STATE_SEL, RST_STATE_SEL, RESP_OKAY);
      axRead(IDX_WAIT_MODE, RST_WAIT_MODE, RESP_OKAY);
      axRead(IDX_WAIT_EN, RST_WAIT_EN, RESP_OKAY);
      axRead(8'h01, 8'h00, RESP_SLVERR);
      axWrite(8'h01, 8'h55, RESP_SLVERR);
      axWrite(IDX_WIDTH_SEL, widthSel, RESP_OKAY);
      axWrite(IDX_STATE_SEL, stateSel, RESP_OKAY);
      axWrite(IDX_WAIT_EN, waitEn, RESP_OKAY);
      axWrite(IDX_WAIT_MODE, 8'h06, RESP_OKAY);
      axRead(IDX_WIDTH_SEL, widthSel, RESP_OKAY);
      axRead(IDX_STATE_SEL, stateSel, RESP_OKAY);
      axRead(IDX_WAIT_EN, waitEn, RESP_OKAY);
      axRead(IDX_WAIT_MODE, 8'hF6, RESP_OKAY);
      access(3'h0, 2'b00, 2'h3, 0);
      for (int c = 0; c < 4; c++)
         access(3'h1, 2'b00, c[1:0], 0);
      access(3'h2, 2'b01, 2'h3, 2);
      access(3'h3, 2'b00, 2'h3, 2);
      access(3'h4, 2'b00, 2'h3, 0);
      access(3'h5, 2'b10, 2'h0, 2);
      access(3'h6, 2'b11, 2'h2, 1);
      access(3'h6, 2'b11, 2'h2, 0);
      access(3'h5, 2'b10, 2'h0, 0);
      access(3'h3, 2'b00, 2'h3, 0);
      access(3'h7, 2'b00, 2'h2, 0);
      axRead(IDX_STATUS, 8'h07, RESP_OKAY);
      test_done();
   end
endmodule
